// ===== dv/gpio_pin_output_selector_test.sv
// self-checking bench for the pin four output router
// assumes the router's wishbone slave and a board reader on its pin
`timescale 1ns/1ns
`default_nettype none
`include "gpio_sel_cfg.svh"
module gpio_pin_output_selector_test
   import gpio_sel_pkg::*;
;
   logic             clk_i = 1'b0;
   logic             rst_i = 1'b1;
   logic             cyc_i = 1'b0;
   logic             stb_i = 1'b0;
   logic             we_i = 1'b0;
   logic [7:0]       adr_i = 8'h00;
   logic [3:0]       sel_i = 4'h0;
   logic [31:0]      dat_i = 32'h0;
   rx_status_t [3:0] rx_stat_i = '0;
   tx_status_t       tx_stat_i = '0;
   logic             frame_sync_pulse_i = 1'b0;
   logic [7:0]       mask_v = 8'hFF;
   wire logic [31:0] dat_o;
   wire logic        ack_o;
   wire logic        pin_o;
   wire logic        pin_oe_o;
   wire logic        level;
   int               fail_count = 0;
   int               checked = 0;
   always #50 clk_i = ~clk_i;
   gpio_pin_output_selector uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rx_stat_i(rx_stat_i),
      .tx_stat_i(tx_stat_i), .frame_sync_pulse_i(frame_sync_pulse_i),
      .pin_o(pin_o), .pin_oe_o(pin_oe_o));
   pin_reader reader (.clk_i(clk_i), .pin_i(pin_o), .oe_i(pin_oe_o),
      .level_o(level));
   // ==========================================================
   // reference of the routing choice
   function automatic logic expect_pin(input logic [7:0] r);
      logic [3:0] lk;
      logic [3:0] ps;
      rx_status_t rx;
      logic [2:0] s;
      s = r[7:5];
      rx = rx_stat_i[r[3:2]];
      for (int i = 0; i < 4; i++) begin
         lk[i] = rx_stat_i[i].lock;
         ps[i] = rx_stat_i[i].pass;
      end
      if (r[4] == 1'b0) begin
         if (s[2] == 1'b0) return rx.remote_gpio[s[1:0]];
         if (s[1] == 1'b0) return s[0] ? rx.pass : rx.lock;
         return s[0] ? rx.line_valid : rx.frame_valid;
      end
      case (r[4:2])
         `SRC_DEV: case (s)
            3'h0: return r[1];
            3'h1: return |(lk & mask_v[3:0]);
            3'h2: return &(ps | ~mask_v[3:0]);
            3'h4: return frame_sync_pulse_i;
            default: return 1'b0;
         endcase
         `SRC_TX: case (s)
            3'h0: return &(ps | ~mask_v[7:4]);
            3'h1: return |(ps & mask_v[7:4]);
            3'h2: return tx_stat_i.frame_active;
            3'h3: return tx_stat_i.line_active;
            3'h4: return tx_stat_i.synced;
            3'h5: return tx_stat_i.irq;
            default: return 1'b0;
         endcase
         default: return 1'b0;
      endcase
   endfunction : expect_pin
   // ==========================================================
   // bus cycle, compare, verdict
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [7:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= {24'h0, d};
      // no local limit: only the watchdog ends a hung cycle
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask : wb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      if (fail_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   // ==========================================================
   // scenarios
   task automatic sweep(input logic [2:0] src);
      logic [31:0] q;
      logic [7:0]  r;
      for (int s = 0; s < 16; s++) begin
         r = {s[2:0], src, s[3], 1'b1};
         @(posedge clk_i);
         rx_stat_i <= s[3] ? ~32'h6C96C53A : 32'h6C96C53A;
         tx_stat_i <= s[3] ? 4'hA : 4'h5;
         frame_sync_pulse_i <= ~s[3];
         wb(1'b1, `ROUTE_OFS, 4'hF, r, q);
         repeat (2) @(posedge clk_i);
         @(negedge clk_i);
         chk({31'h0, pin_o}, {31'h0, expect_pin(r)});
         chk({31'h0, level}, {31'h0, expect_pin(r)});
      end
   endtask : sweep
   task automatic t_reset;
      logic [31:0] q;
      wb(1'b0, `ROUTE_OFS, 4'hF, 8'h00, q);
      chk(q, {24'h0, `ROUTE_RST});
      wb(1'b0, `MASK_OFS, 4'hF, 8'h00, q);
      chk(q, {24'h0, `MASK_RST});
      chk({31'h0, pin_oe_o}, 32'h0);
      chk({31'h0, pin_o}, 32'h0);
      // all rx status is zero here, so no lock and a low pin
      wb(1'b0, `STATUS_OFS, 4'hF, 8'h00, q);
      chk(q, 32'h0);
   endtask : t_reset
   task automatic t_rx;
      for (int p = 0; p < 4; p++) sweep(p[2:0]);
   endtask : t_rx
   task automatic t_masked(input logic [2:0] src, input logic [7:0] m);
      logic [31:0] q;
      wb(1'b1, `MASK_OFS, 4'hF, m, q);
      mask_v = m;
      sweep(src);
   endtask : t_masked
   task automatic t_rsvd;
      logic [31:0] q;
      logic [3:0]  lk;
      sweep(3'h5);
      sweep(3'h7);
      for (int i = 0; i < 4; i++) lk[i] = rx_stat_i[i].lock;
      // routing is 0xFF now: reserved code flagged, driver on, pin low
      wb(1'b0, `STATUS_OFS, 4'hF, 8'h00, q);
      chk(q, {24'h0, lk, 4'b0110});
      wb(1'b1, `ROUTE_OFS, 4'hF, 8'h12, q);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk({31'h0, pin_oe_o}, 32'h0);
      chk({31'h0, pin_o}, 32'h1);
      wb(1'b0, `STATUS_OFS, 4'hF, 8'h00, q);
      chk(q, {24'h0, lk, 4'b0001});
      wb(1'b1, `ROUTE_OFS, 4'h0, 8'hFF, q);
      wb(1'b0, `ROUTE_OFS, 4'hF, 8'h00, q);
      chk(q, 32'h12);
      wb(1'b0, 8'h20, 4'hF, 8'h00, q);
      chk(q, 32'h0);
   endtask : t_rsvd
   task automatic t_rerun;
      logic [31:0] q;
      // reset in mid-run must bring back the idle pin and reset values
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk({31'h0, pin_oe_o}, 32'h0);
      chk({31'h0, pin_o}, 32'h0);
      wb(1'b0, `ROUTE_OFS, 4'hF, 8'h00, q);
      chk(q, {24'h0, `ROUTE_RST});
      wb(1'b0, `MASK_OFS, 4'hF, 8'h00, q);
      chk(q, {24'h0, `MASK_RST});
   endtask : t_rerun
   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_rx();
      t_masked(`SRC_DEV, 8'h5A);
      t_masked(`SRC_DEV, 8'hFF);
      t_masked(`SRC_TX, 8'hA5);
      t_masked(`SRC_TX, 8'h3C);
      t_rsvd();
      t_rerun();
      print_verdict();
   end
   initial begin
      // whole sweep needs about 1000 cycles; the 20000-cycle limit allows over fifteen times that
      #2000000;
      fail_count++;
      print_verdict();
   end
endmodule : gpio_pin_output_selector_test
`default_nettype wire

// ===== dv/pin_reader.sv
// board-side reader of general-purpose pin four
// assumes no pull on the pin; undriven it must not echo the old level
`timescale 1ns/1ns
`default_nettype none
module pin_reader (
   input  wire logic clk_i,   // core clock
   input  wire logic pin_i,   // level from the router
   input  wire logic oe_i,    // router driver enable
   output logic      level_o  // level seen on the board
);
   logic last_reg = 1'b0;
   // a floating pin shows the inverse, so a dead enable cannot pass
   assign level_o = oe_i ? pin_i : ~last_reg;
   always_ff @(posedge clk_i) begin
      if (oe_i) begin
         last_reg <= pin_i;
      end
   end
endmodule : pin_reader
`default_nettype wire

// ===== verilog/gpio_pin_output_selector.sv
// routing of internal status onto general-purpose pin four
// assumes status inputs run on clk_i; pin buffer outside the block
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_sel_cfg.svh"
module gpio_pin_output_selector
   import gpio_sel_pkg::*;
#(
   parameter int ADR_W = 8,
   parameter int PORTS = 4
) (
   input  wire logic             clk_i,     // core clock 10 MHz
   input  wire logic             rst_i,     // sync reset, high
   input  wire logic             cyc_i,     // wishbone cycle
   input  wire logic             stb_i,     // wishbone strobe
   input  wire logic             we_i,      // wishbone write
   input  wire logic [ADR_W-1:0] adr_i,     // byte address
   input  wire logic [3:0]       sel_i,     // byte enables
   input  wire logic [31:0]      dat_i,     // write data
   output logic      [31:0]      dat_o,     // read data
   output logic                  ack_o,     // wishbone ack
   input  wire rx_status_t [PORTS-1:0] rx_stat_i, // rx port status
   input  wire tx_status_t       tx_stat_i, // transmit status
   input  wire logic             frame_sync_pulse_i, // sync gen
   output logic                  pin_o,     // pin level
   output logic                  pin_oe_o   // pin driver enable
);
   // ==========================================================
   // registers
   logic [7:0] pin_four_output_routing_reg;
   logic [7:0] mask_reg;
   logic       ack_reg;
   logic [31:0] dat_reg;
   pin_drive_t drive_reg;
   pin_drive_t drive_next;

   // ==========================================================
   // bus decode
   wire req      = cyc_i & stb_i;
   wire hit_rt   = adr_i == ADR_W'(`ROUTE_OFS);
   wire hit_st   = adr_i == ADR_W'(`STATUS_OFS);
   wire hit_mk   = adr_i == ADR_W'(`MASK_OFS);
   // writes land on the edge where the master sees ack
   wire wr_do    = req & we_i & ack_reg & sel_i[0];
   wire wr_rt    = wr_do & hit_rt;
   wire wr_mk    = wr_do & hit_mk;

   // ==========================================================
   // field views
   wire [2:0] source_choice_field =
      pin_four_output_routing_reg[`SRC_HI:`SRC_LO];
   wire [2:0] signal_choice_field =
      pin_four_output_routing_reg[`SEL_HI:`SEL_LO];
   wire       software_level_bit =
      pin_four_output_routing_reg[`VAL_BIT];
   wire       driver_enable_bit =
      pin_four_output_routing_reg[`EN_BIT];
   wire [PORTS-1:0] rx_en_mask  = mask_reg[PORTS-1:0];
   wire [PORTS-1:0] tx_sel_mask = mask_reg[PORTS+3:4];

   // ==========================================================
   // gather per-port status into vectors
   logic [PORTS-1:0] lock_vec;
   logic [PORTS-1:0] pass_vec;
   always_comb begin
      for (int i = 0; i < PORTS; i++) begin
         lock_vec[i] = rx_stat_i[i].lock;
         pass_vec[i] = rx_stat_i[i].pass;
      end
   end

   // ==========================================================
   // receive port source: code order matches the vector order
   wire        src_is_rx = ~source_choice_field[2];
   rx_status_t rx_pick;
   assign rx_pick = rx_stat_i[source_choice_field[1:0]];
   wire [7:0] rx_vec = {rx_pick.line_valid,
                        rx_pick.frame_valid,
                        rx_pick.pass,
                        rx_pick.lock,
                        rx_pick.remote_gpio};
   wire rx_level = rx_vec[signal_choice_field];

   // ==========================================================
   // device status source
   // with no port enabled the AND of pass reads high (empty AND)
   wire lock_or  = |(lock_vec & rx_en_mask);
   wire pass_and = &(pass_vec | ~rx_en_mask);
   wire [7:0] dev_vec = {3'b000, frame_sync_pulse_i, 1'b0,
                         pass_and, lock_or, software_level_bit};
   wire src_is_dev = source_choice_field == `SRC_DEV;
   wire dev_ok = signal_choice_field != `SEL_DEV_RSVD &&
                 signal_choice_field <= `SEL_DEV_MAX;
   wire dev_level = dev_vec[signal_choice_field];

   // ==========================================================
   // transmit port source
   wire tx_and = &(pass_vec | ~tx_sel_mask);
   wire tx_or  = |(pass_vec & tx_sel_mask);
   wire [7:0] tx_vec = {2'b00, tx_stat_i.irq,
                        tx_stat_i.synced,
                        tx_stat_i.line_active,
                        tx_stat_i.frame_active,
                        tx_or, tx_and};
   wire src_is_tx = source_choice_field == `SRC_TX;
   wire tx_ok = signal_choice_field <= `SEL_TX_MAX;
   wire tx_level = tx_vec[signal_choice_field];

   // ==========================================================
   // final selection; reserved codes give a steady low
   wire route_ok = src_is_rx | (src_is_dev & dev_ok) |
                   (src_is_tx & tx_ok);
   wire sel_level = src_is_rx  ? rx_level  :
                    src_is_dev ? dev_level :
                    src_is_tx  ? tx_level  : 1'b0;
   assign drive_next.level = route_ok & sel_level;
   assign drive_next.oe    = driver_enable_bit;

   // ==========================================================
   // read mux
   wire [31:0] rd_data =
      hit_rt ? {24'h000000, pin_four_output_routing_reg} :
      hit_mk ? {24'h000000, mask_reg} :
      hit_st ? {24'h000000, lock_vec, 1'b0, ~route_ok,
                drive_reg.oe, drive_reg.level} :
      32'h00000000;

   // ==========================================================
   // clocked state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_four_output_routing_reg <= `ROUTE_RST;
         mask_reg  <= `MASK_RST;
      end else begin
         if (wr_rt) pin_four_output_routing_reg <= dat_i[7:0];
         if (wr_mk) mask_reg <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= req & ~ack_reg;
         if (req & ~ack_reg) dat_reg <= rd_data;
      end
   end

   // the pin is retimed so it never glitches on a mux change
   always_ff @(posedge clk_i) begin
      if (rst_i) drive_reg <= '0;
      else       drive_reg <= drive_next;
   end

   assign ack_o    = ack_reg;
   assign dat_o    = dat_reg;
   assign pin_o    = drive_reg.level;
   assign pin_oe_o = drive_reg.oe;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence bus_req_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence bus_ack_s;
      ack_o ##1 !ack_o;
   endsequence
   sequence route_wr_s;
      cyc_i && stb_i && we_i && ack_o && sel_i[0] &&
      adr_i == ADR_W'(`ROUTE_OFS);
   endsequence

   bus_ack_once_a: assert property (
      bus_req_s |=> bus_ack_s)
      else $error("ack not a single pulse after request");

   enable_write_a: assert property (
      route_wr_s |=> ##1 pin_oe_o == $past(dat_i[0], 2))
      else $error("pin enable does not follow written bit");

   rx_gpio_route_a: assert property (
      src_is_rx && signal_choice_field < 3'h4 |=>
      pin_o == $past(rx_pick.remote_gpio[signal_choice_field[1:0]]))
      else $error("remote gpio not routed to pin");

   rx_lock_route_a: assert property (
      src_is_rx && signal_choice_field == 3'h4 |=>
      pin_o == $past(rx_stat_i[source_choice_field[1:0]].lock))
      else $error("rx lock not routed to pin");

   rx_frame_route_a: assert property (
      src_is_rx && signal_choice_field == 3'h6 |=>
      pin_o == $past(rx_pick.frame_valid))
      else $error("rx frame valid not routed to pin");

   sw_level_a: assert property (
      src_is_dev && signal_choice_field == 3'h0 |=>
      pin_o == $past(pin_four_output_routing_reg[1]))
      else $error("software level not on pin");

   dev_lock_or_a: assert property (
      src_is_dev && signal_choice_field == 3'h1 |=>
      pin_o == $past(|(lock_vec & mask_reg[3:0])))
      else $error("device lock OR wrong");

   tx_pass_and_a: assert property (
      src_is_tx && signal_choice_field == 3'h0 &&
      (pass_vec & mask_reg[7:4]) != mask_reg[7:4] |=> !pin_o)
      else $error("tx pass AND high with a failing port");

   tx_irq_route_a: assert property (
      src_is_tx && signal_choice_field == 3'h5 |=>
      pin_o == $past(tx_stat_i.irq))
      else $error("tx interrupt not routed");

   src_rsvd_low_a: assert property (
      source_choice_field == 3'h5 || source_choice_field == 3'h7
      |=> !pin_o)
      else $error("reserved source drives high");

   sel_rsvd_low_a: assert property (
      !route_ok [*2] |-> ##1 !pin_o [*1])
      else $error("reserved selection drives high");

   // ==========================================================
   // remaining routes, driver and bus checks
   rx_pass_route_a: assert property (
      src_is_rx && signal_choice_field == 3'h5 |=>
      pin_o == $past(rx_pick.pass))
      else $error("rx pass not routed to pin");

   rx_line_route_a: assert property (
      src_is_rx && signal_choice_field == 3'h7 |=>
      pin_o == $past(rx_pick.line_valid))
      else $error("rx line valid not routed to pin");

   dev_pass_and_a: assert property (
      src_is_dev && signal_choice_field == 3'h2 &&
      (pass_vec & mask_reg[3:0]) != mask_reg[3:0] |=> !pin_o)
      else $error("device pass AND high with a failing port");

   dev_sync_route_a: assert property (
      src_is_dev && signal_choice_field == 3'h4 |=>
      pin_o == $past(frame_sync_pulse_i))
      else $error("frame sync not routed to pin");

   tx_pass_or_a: assert property (
      src_is_tx && signal_choice_field == 3'h1 &&
      (pass_vec & mask_reg[7:4]) != 4'h0 |=> pin_o)
      else $error("tx pass OR low with a passing port");

   tx_frame_route_a: assert property (
      src_is_tx && signal_choice_field == 3'h2 |=>
      pin_o == $past(tx_stat_i.frame_active))
      else $error("tx frame activity not routed");

   tx_line_route_a: assert property (
      src_is_tx && signal_choice_field == 3'h3 |=>
      pin_o == $past(tx_stat_i.line_active))
      else $error("tx line activity not routed");

   tx_sync_route_a: assert property (
      src_is_tx && signal_choice_field == 3'h4 |=>
      pin_o == $past(tx_stat_i.synced))
      else $error("tx synced indication not routed");

   driver_off_a: assert property (
      !driver_enable_bit |=> !pin_oe_o)
      else $error("pin driver on while disabled");

   driver_on_a: assert property (
      driver_enable_bit |=> pin_oe_o)
      else $error("pin driver off while enabled");

   dev_rsvd_low_a: assert property (
      src_is_dev && (signal_choice_field == 3'h3 ||
      signal_choice_field > 3'h4) |=> !pin_o)
      else $error("reserved device selection drives high");

   tx_rsvd_low_a: assert property (
      src_is_tx && signal_choice_field > 3'h5 |=> !pin_o)
      else $error("reserved tx selection drives high");

   route_keep_a: assert property (
      cyc_i && stb_i && we_i && ack_o && !sel_i[0] |=>
      $stable(pin_four_output_routing_reg))
      else $error("masked write changed the routing register");

   unmapped_zero_a: assert property (
      cyc_i && stb_i && !ack_o && !hit_rt && !hit_st && !hit_mk
      |=> dat_o == 32'h00000000)
      else $error("unmapped read returns nonzero data");

   bus_data_hi_a: assert property (
      ack_o |-> dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");

   pin_reset_a: assert property (
      $fell(rst_i) |-> !pin_oe_o && !pin_o && !ack_o)
      else $error("outputs not idle after reset");

endmodule : gpio_pin_output_selector
`default_nettype wire

// ===== verilog/gpio_sel_cfg.svh
// offsets, field positions, codes and reset values of the pin router
// assumes byte addressing on a 32-bit classic Wishbone bus
`ifndef GPIO_SEL_CFG_SVH
`define GPIO_SEL_CFG_SVH
// ==========================================================
// register byte addresses
`define ROUTE_OFS     8'h14
`define STATUS_OFS    8'h18
`define MASK_OFS      8'h1C
// ==========================================================
// routing register fields and the reset values of both registers
`define SEL_HI        7
`define SEL_LO        5
`define SRC_HI        4
`define SRC_LO        2
`define VAL_BIT       1
`define EN_BIT        0
`define ROUTE_RST     8'h00
`define MASK_RST      8'hFF
// ==========================================================
// source codes
`define SRC_DEV       3'h4
`define SRC_TX        3'h6
// selection codes
`define SEL_DEV_RSVD  3'h3
`define SEL_DEV_MAX   3'h4
`define SEL_TX_MAX    3'h5
`endif

// ===== verilog/gpio_sel_pkg.sv
// types shared by the pin router and its surroundings
// assumes nothing beyond the cfg header
package gpio_sel_pkg;
   // ==========================================================
   // status of one receive port
   typedef struct packed {
      logic       line_valid;
      logic       frame_valid;
      logic       pass;
      logic       lock;
      logic [3:0] remote_gpio;
   } rx_status_t;
   // ==========================================================
   // status of the transmit port
   typedef struct packed {
      logic irq;
      logic synced;
      logic line_active;
      logic frame_active;
   } tx_status_t;
   // ==========================================================
   // pin drive pair
   typedef struct packed {
      logic level;
      logic oe;
   } pin_drive_t;
endpackage : gpio_sel_pkg
